// ---- logic/rcm_lane_ctrl.sv ----
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1: Reference mode locks on reference phase match.
// R2: Data mode locks after valid incoming data.
// R3: Burst mode uses two-bit tracking select input.
// R4: Codes 01 high, 10 reference, 11 normal.
// R5: Fabric picks high gain, then normal.
// R6: No decision-feedback calibration in burst mode.
// R7: Double-gain data mode locks faster.
// R8: Shift request edge moves boundary one bit.
// R9: Fabric requests while valid, drops after low.
// R10: Shift request drives word-valid low.
// R11: Word-valid returns high on parallel clock.
// R12: Shifting only when coding layer bypassed.
// R13: Shift may move either direction.
// R14: Deserializer chunks never exceed forty bits.
// R15: Divider sets eight selectable word widths.
// R16: Calibration runs offset, equalizer, feedback stages.
// R17: Offset found by binary search, input zeroed.
// R18: Equalizer sweep keeps largest eye area.
// R19: New shift edges ignored until valid returns.
module rcm_lane_ctrl
  import rcm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic [1:0] tracking_mode_select,
  input wire logic ref_phase_match,
  input wire logic data_transition,
  input wire logic ser_bit,
  input wire logic ser_bit_en,
  input wire logic bit_slip_req,
  output logic recv_word_valid,
  output logic [WORD_W-1:0] rx_word,
  output logic rx_word_strobe,
  output logic cdr_lock,
  output logic dco_zero_input,
  output logic [DCO_W-1:0] dco_offset,
  input wire logic amp_out,
  output logic [EQ_W-1:0] eq_setting,
  input wire logic [EYE_W-1:0] eye_area,
  output logic dfe_start,
  input wire logic dfe_done
);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  rcm_ctrl_t ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] wmask;
  logic bus_req;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic cal_go;
  rcm_cal_state_t cal_state;
  rcm_slip_state_t slip_state;
  logic [EQ_W-1:0] eq_best;
  logic [1:0] trk_used;

  // One access per handshake: ack is given one cycle after the request and
  // dropped the cycle after, so a request still held in its ack cycle is not taken twice.
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wr_ctrl = bus_req && wb_we_i && (wb_adr_i == ADDR_CTRL);
  assign wr_stat = bus_req && wb_we_i && (wb_adr_i == ADDR_IRQ_STAT);
  assign wr_mask = bus_req && wb_we_i && (wb_adr_i == ADDR_IRQ_MASK);
  assign cal_go = wr_ctrl && wb_sel_i[1] && wb_dat_i[CTRL_CAL_START];

  // Answer and read data, registered; unmapped offsets read zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i == ADDR_CTRL) begin
          wb_dat_o[CTRL_W-1:0] <= ctrl;
        end else if (wb_adr_i == ADDR_STATUS) begin
          wb_dat_o[ST_LOCK] <= cdr_lock;
          wb_dat_o[ST_VALID] <= recv_word_valid;
          wb_dat_o[ST_CAL_BUSY] <= (cal_state != CAL_IDLE);
          wb_dat_o[ST_DCO_LSB +: DCO_W] <= dco_offset;
          wb_dat_o[ST_EQ_LSB +: EQ_W] <= eq_best;
          wb_dat_o[ST_TRK_LSB +: 2] <= trk_used;
        end else if (wb_adr_i == ADDR_IRQ_STAT) begin
          wb_dat_o[IRQ_W-1:0] <= irq_stat;
        end else if (wb_adr_i == ADDR_IRQ_MASK) begin
          wb_dat_o[IRQ_W-1:0] <= irq_mask;
        end
      end
    end
  end

  // Control register, byte lanes honoured.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= rcm_ctrl_t'(CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl <= rcm_ctrl_t'((ctrl & wmask[CTRL_W-1:0]) ^ ctrl |
                          (wb_dat_i[CTRL_W-1:0] & wmask[CTRL_W-1:0]));
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************

  // Write one to clear; a new event in the same cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_stat) begin
        irq_stat <= (irq_stat & ~(wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]))
                    | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
      if (wr_mask) begin
        irq_mask <= (irq_mask & ~wmask[IRQ_W-1:0]) |
                    (wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
      end
      irq <= |((irq_stat | irq_set) & irq_mask);
    end
  end

  // ****************************************************************
  // Recovery loop lock detection
  // ****************************************************************
  logic [7:0] lock_cnt;
  logic [7:0] lock_target;
  logic use_ref;
  logic hold_lock;
  logic [1:0] trk_prev;

  // Pick the tracking behaviour; outside burst mode the static mode decides.
  always_comb begin
    trk_used = TRK_NORMAL;
    lock_target = LOCK_CNT_NORMAL;
    if (ctrl.mode == MODE_BURST) begin
      trk_used = tracking_mode_select; // R3
    end else if (ctrl.mode == MODE_REF) begin
      trk_used = TRK_REF;
    end
    case (trk_used) // R4
      TRK_HIGH_GAIN: lock_target = LOCK_CNT_HIGH;
      TRK_REF: lock_target = LOCK_CNT_REF;
      default: lock_target = LOCK_CNT_NORMAL;
    endcase
    if (ctrl.mode == MODE_DATA_2X) begin
      lock_target = LOCK_CNT_DOUBLE; // R7
    end
    use_ref = (trk_used == TRK_REF);
    hold_lock = (trk_used == TRK_UNUSED); // R4
  end

  // Lock counts qualifying cycles; any change of tracking restarts it, except a change to the unused code, which holds it.
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_cnt <= 8'h00;
      cdr_lock <= 1'b0;
      trk_prev <= TRK_NORMAL;
    end else begin
      trk_prev <= trk_used;
      if (hold_lock) begin
        lock_cnt <= lock_cnt;
      end else if (trk_used != trk_prev) begin
        lock_cnt <= 8'h00;
        cdr_lock <= 1'b0;
      end else if (use_ref ? !ref_phase_match : !data_transition) begin
        lock_cnt <= 8'h00; // R1 R2
        cdr_lock <= 1'b0;
      end else if (lock_cnt >= lock_target - 8'h01) begin
        cdr_lock <= 1'b1; // R1 R2
      end else begin
        lock_cnt <= lock_cnt + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Deserializer, divider and word boundary shift
  // ****************************************************************
  logic [DESER_W-1:0] shreg;
  logic [DESER_W-1:0] next_shreg;
  logic [6:0] bit_cnt;
  logic [6:0] next_cnt;
  logic [6:0] chunk_bits;
  logic wide;
  logic half_got;
  logic [DESER_W-1:0] low_half;
  logic [DESER_W-1:0] chunk;
  logic chunk_done;
  logic word_done;
  logic slip_pending;
  logic slip_dir;
  logic slip_apply;
  logic req_prev;
  logic req_rise;

  always_comb begin
    chunk_bits = rcm_chunk_bits(ctrl.width); // R14 R15
    wide = rcm_word_bits(ctrl.width) > chunk_bits;
    next_shreg = {shreg[DESER_W-2:0], ser_bit};
    slip_apply = ser_bit_en && slip_pending;
    // A later boundary leaves one bit uncounted, an earlier one counts two.
    if (slip_apply && !slip_dir) begin
      next_cnt = bit_cnt; // R8 R13
    end else if (slip_apply) begin
      next_cnt = bit_cnt + 7'h02; // R8 R13
    end else begin
      next_cnt = bit_cnt + 7'h01;
    end
    chunk_done = ser_bit_en && (next_cnt >= chunk_bits);
    chunk = next_shreg & ~({DESER_W{1'b1}} << chunk_bits);
    word_done = chunk_done && (!wide || half_got);
  end

  // Serial bits gather into chunks; wide words pair two chunks, low first.
  always_ff @(posedge clk) begin
    if (srst) begin
      shreg <= '0;
      bit_cnt <= 7'h00;
      half_got <= 1'b0;
      low_half <= '0;
      rx_word <= '0;
      rx_word_strobe <= 1'b0;
    end else begin
      rx_word_strobe <= word_done;
      if (ser_bit_en) begin
        shreg <= next_shreg;
        bit_cnt <= chunk_done ? next_cnt - chunk_bits : next_cnt;
      end
      if (chunk_done && wide && !half_got) begin
        low_half <= chunk;
        half_got <= 1'b1;
      end else if (word_done) begin
        half_got <= 1'b0;
        if (wide) begin
          rx_word <= ({{DESER_W{1'b0}}, chunk} << chunk_bits) |
                     {{DESER_W{1'b0}}, low_half}; // R15
        end else begin
          rx_word <= {{DESER_W{1'b0}}, chunk};
        end
      end
    end
  end

  assign req_rise = bit_slip_req && !req_prev;

  // Shift handshake: valid drops, the fabric releases, one bit moves, and
  // valid comes back with the next parallel word.
  always_ff @(posedge clk) begin
    if (srst) begin
      slip_state <= SLIP_READY;
      recv_word_valid <= 1'b1;
      slip_pending <= 1'b0;
      slip_dir <= 1'b0;
      req_prev <= 1'b0;
    end else begin
      req_prev <= bit_slip_req;
      case (slip_state)
        SLIP_READY: begin
          // Only a bypassed coding layer lets the fabric move the boundary.
          if (req_rise && recv_word_valid && ctrl.coding_bypass) begin // R12
            recv_word_valid <= 1'b0; // R10
            slip_dir <= ctrl.slip_earlier; // R13
            slip_state <= SLIP_WAIT_LOW;
          end
        end
        SLIP_WAIT_LOW: begin
          // Further edges are ignored until valid is back.
          if (!bit_slip_req) begin // R19
            slip_pending <= 1'b1;
            slip_state <= SLIP_SHIFT;
          end
        end
        SLIP_SHIFT: begin
          if (slip_apply) begin
            slip_pending <= 1'b0;
          end
          if (!slip_pending && word_done) begin
            recv_word_valid <= 1'b1; // R11
            slip_state <= SLIP_READY;
          end
        end
        default: slip_state <= SLIP_READY;
      endcase
    end
  end

  // ****************************************************************
  // Receiver calibration
  // ****************************************************************
  logic [3:0] settle;
  logic [2:0] dco_bit;
  logic [EYE_W-1:0] eye_best;

  // Each trial value is held for a settle time before its result is read.
  always_ff @(posedge clk) begin
    if (srst) begin
      cal_state <= CAL_IDLE;
      settle <= 4'h0;
      dco_bit <= 3'h0;
      dco_offset <= '0;
      dco_zero_input <= 1'b0;
      eq_setting <= '0;
      eq_best <= '0;
      eye_best <= '0;
      dfe_start <= 1'b0;
    end else begin
      dfe_start <= 1'b0;
      settle <= (settle == 4'h0) ? 4'h0 : settle - 4'h1;
      case (cal_state)
        CAL_IDLE: begin
          if (cal_go) begin // R16
            dco_zero_input <= 1'b1; // R17
            dco_bit <= 3'(DCO_W - 1);
            dco_offset <= {1'b1, {(DCO_W-1){1'b0}}};
            settle <= CAL_SETTLE;
            cal_state <= CAL_DCO;
          end
        end
        CAL_DCO: begin
          if (settle == 4'h0) begin
            // A high output means the trial offset overshoots.
            if (amp_out) begin
              dco_offset[dco_bit] <= 1'b0; // R17
            end
            if (dco_bit == 3'h0) begin
              dco_zero_input <= 1'b0;
              eq_setting <= '0;
              eye_best <= '0;
              eq_best <= '0;
              cal_state <= CAL_EQ;
            end else begin
              dco_offset[dco_bit - 3'h1] <= 1'b1;
              dco_bit <= dco_bit - 3'h1;
            end
            settle <= CAL_SETTLE;
          end
        end
        CAL_EQ: begin
          if (settle == 4'h0) begin
            if (eye_area > eye_best) begin
              eye_best <= eye_area; // R18
              eq_best <= eq_setting;
            end
            settle <= CAL_SETTLE;
            if (eq_setting == EQ_LAST) begin
              eq_setting <= (eye_area > eye_best) ? eq_setting : eq_best;
              // Burst lanes skip the feedback stage altogether.
              if (ctrl.dfe_en && ctrl.mode != MODE_BURST) begin // R6
                dfe_start <= 1'b1; // R16
                cal_state <= CAL_DFE;
              end else begin
                cal_state <= CAL_DONE;
              end
            end else begin
              eq_setting <= eq_setting + 3'h1;
            end
          end
        end
        CAL_DFE: begin
          if (dfe_done) begin
            cal_state <= CAL_DONE;
          end
        end
        CAL_DONE: cal_state <= CAL_IDLE;
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end

  // Event sources for the sticky status bits.
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_LOCK_UP] = !cdr_lock && !hold_lock && !use_ref
      ? (data_transition && lock_cnt >= lock_target - 8'h01
         && trk_used == trk_prev)
      : (!cdr_lock && !hold_lock && ref_phase_match
         && lock_cnt >= lock_target - 8'h01 && trk_used == trk_prev);
    irq_set[IRQ_LOCK_LOST] = cdr_lock && !hold_lock &&
      ((trk_used != trk_prev) ||
       (use_ref ? !ref_phase_match : !data_transition));
    irq_set[IRQ_CAL_DONE] = (cal_state == CAL_DONE);
    irq_set[IRQ_SLIP_DONE] = (slip_state == SLIP_SHIFT) && !slip_pending
                             && word_done;
  end

endmodule
`default_nettype wire

// ---- logic/rcm_pkg.sv ----
package rcm_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

  localparam int CTRL_W = 8;
  localparam int CTRL_CAL_START = 8;
  localparam logic [7:0] CTRL_RESET = 8'h51;

  localparam int ST_LOCK = 0;
  localparam int ST_VALID = 1;
  localparam int ST_CAL_BUSY = 2;
  localparam int ST_DCO_LSB = 8;
  localparam int ST_EQ_LSB = 16;
  localparam int ST_TRK_LSB = 20;

  localparam int IRQ_W = 4;
  localparam int IRQ_LOCK_UP = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_CAL_DONE = 2;
  localparam int IRQ_SLIP_DONE = 3;

  // ****************************************************************
  // Recovery loop modes, burst tracking codes and lock thresholds
  // ****************************************************************
  localparam logic [1:0] MODE_REF = 2'h0;
  localparam logic [1:0] MODE_DATA = 2'h1;
  localparam logic [1:0] MODE_BURST = 2'h2;
  localparam logic [1:0] MODE_DATA_2X = 2'h3;

  localparam logic [1:0] TRK_UNUSED = 2'h0;
  localparam logic [1:0] TRK_HIGH_GAIN = 2'h1;
  localparam logic [1:0] TRK_REF = 2'h2;
  localparam logic [1:0] TRK_NORMAL = 2'h3;

  localparam logic [7:0] LOCK_CNT_REF = 8'h20;
  localparam logic [7:0] LOCK_CNT_NORMAL = 8'h40;
  localparam logic [7:0] LOCK_CNT_DOUBLE = 8'h20;
  localparam logic [7:0] LOCK_CNT_HIGH = 8'h10;

  // ****************************************************************
  // Word widths and calibration constants
  // ****************************************************************
  localparam int DESER_W = 40;
  localparam int WORD_W = 80;
  localparam int DCO_W = 6;
  localparam int EQ_W = 3;
  localparam logic [EQ_W-1:0] EQ_LAST = 3'h7;
  localparam int EYE_W = 16;
  localparam logic [3:0] CAL_SETTLE = 4'h8;

  typedef struct packed {
    logic dfe_en;
    logic [2:0] width;
    logic slip_earlier;
    logic coding_bypass;
    logic [1:0] mode;
  } rcm_ctrl_t;

  typedef enum logic [4:0] {
    CAL_IDLE = 5'b00001,
    CAL_DCO = 5'b00010,
    CAL_EQ = 5'b00100,
    CAL_DFE = 5'b01000,
    CAL_DONE = 5'b10000
  } rcm_cal_state_t;

  typedef enum logic [2:0] {
    SLIP_READY = 3'b001,
    SLIP_WAIT_LOW = 3'b010,
    SLIP_SHIFT = 3'b100
  } rcm_slip_state_t;

  // Fabric word width for each divider setting.
  function automatic logic [6:0] rcm_word_bits(input logic [2:0] code);
    case (code)
      3'h0: rcm_word_bits = 7'h08;
      3'h1: rcm_word_bits = 7'h0A;
      3'h2: rcm_word_bits = 7'h10;
      3'h3: rcm_word_bits = 7'h14;
      3'h4: rcm_word_bits = 7'h20;
      3'h5: rcm_word_bits = 7'h28;
      3'h6: rcm_word_bits = 7'h40;
      default: rcm_word_bits = 7'h50;
    endcase
  endfunction

  // Deserializer chunk width: wide words arrive as two halves.
  function automatic logic [6:0] rcm_chunk_bits(input logic [2:0] code);
    logic [6:0] w;
    w = rcm_word_bits(code);
    rcm_chunk_bits = (w > 7'h28) ? {1'b0, w[6:1]} : w;
  endfunction

endpackage

// ---- tb/rcm_lane_ctrl_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
// *****
// Port checker for the lane control block.
// *****
module rcm_lane_ctrl_checker
  import rcm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ref_phase_match,
  input wire logic data_transition,
  input wire logic bit_slip_req,
  input wire logic recv_word_valid,
  input wire logic rx_word_strobe,
  input wire logic cdr_lock,
  input wire logic dco_zero_input,
  input wire logic [DCO_W-1:0] dco_offset,
  input wire logic dfe_start
);
  logic [7:0] run;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Consecutive cycles with a lock condition; it saturates so that a
  // long run never wraps back under the smallest threshold.
  always_ff @(posedge clk) begin
    if (srst || !(ref_phase_match || data_transition)) begin
      run <= 8'h00;
    end else if (run != 8'hFF) begin
      run <= run + 8'h01;
    end
  end
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside the ack cycle");
  AST_VALID_RISE: assert property (
    $rose(recv_word_valid) |-> rx_word_strobe)
    else $error("word valid back without a word strobe");
  AST_VALID_FALL: assert property (
    $fell(recv_word_valid) |-> $past(bit_slip_req) && !$past(bit_slip_req, 2))
    else $error("word valid fell without a fresh shift request");
  AST_LOCK_RUN: assert property (
    $rose(cdr_lock) |-> run >= 8'h10)
    else $error("lock came too early");
  AST_LOCK_DROP: assert property (
    cdr_lock && !ref_phase_match && !data_transition |=> !cdr_lock)
    else $error("lock held after its condition went");
  AST_DFE_PULSE: assert property (dfe_start |=> !dfe_start)
    else $error("feedback start longer than one cycle");
  AST_DCO_SEARCH: assert property (
    $changed(dco_offset) |-> dco_zero_input || $past(dco_zero_input))
    else $error("offset moved outside the search");
  COV_LOCK: cover property ($rose(cdr_lock));
  COV_SHIFT: cover property ($rose(recv_word_valid));
  COV_DFE: cover property (dfe_start);
endmodule

bind rcm_lane_ctrl rcm_lane_ctrl_checker u_chk (
  .clk(clk),
  .srst(srst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .ref_phase_match(ref_phase_match),
  .data_transition(data_transition),
  .bit_slip_req(bit_slip_req),
  .recv_word_valid(recv_word_valid),
  .rx_word_strobe(rx_word_strobe),
  .cdr_lock(cdr_lock),
  .dco_zero_input(dco_zero_input),
  .dco_offset(dco_offset),
  .dfe_start(dfe_start)
);
`default_nettype wire

// ---- tb/rcm_fabric_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// *****
// Fabric side: serial source and shift handshake.
// *****
module rcm_fabric_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic slip_go,
  input wire logic rude,
  input wire logic recv_word_valid,
  output logic bit_slip_req,
  output logic ser_bit,
  output logic ser_bit_en
);
  logic [7:0] pat;
  logic done;
  // A lopsided byte repeats on the line, so a one-bit boundary move
  // always gives a word that differs from the aligned one.
  assign ser_bit = pat[0];
  always_ff @(posedge clk) begin
    if (srst) begin
      pat <= 8'h1D;
      ser_bit_en <= 1'b0;
    end else begin
      pat <= {pat[0], pat[7:1]};
      ser_bit_en <= 1'b1;
    end
  end
  // Request only while valid is high and drop it once valid is seen
  // low. The rude input re-raises it while valid is still low.
  always_ff @(posedge clk) begin
    if (srst) begin
      bit_slip_req <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= slip_go && (done || !recv_word_valid);
      bit_slip_req <= (slip_go && !done && recv_word_valid) ||
        (rude && !recv_word_valid && !bit_slip_req);
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_rcm_lane_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_rcm_lane_ctrl
  import rcm_pkg::*;
();
  localparam logic [5:0] DCO_GOAL = 6'h2B;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [1:0] tracking_mode_select = TRK_NORMAL;
  logic ref_phase_match = 1'b0;
  logic data_transition = 1'b0;
  logic dfe_done = 1'b0;
  logic slip_go = 1'b0;
  logic rude = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq, bit_slip_req, ser_bit, ser_bit_en;
  logic recv_word_valid, rx_word_strobe, cdr_lock, dco_zero_input;
  logic dfe_start, amp_out;
  logic [WORD_W-1:0] rx_word;
  logic [DCO_W-1:0] dco_offset;
  logic [EQ_W-1:0] eq_setting;
  logic [EYE_W-1:0] eye_area;
  logic [7:0] w0, w1;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int dfe_seen = 0;
  int n;
  logic [1:0] lk_mode [6] = '{MODE_REF, MODE_DATA, MODE_DATA_2X,
    MODE_BURST, MODE_BURST, MODE_BURST};
  logic [1:0] lk_trk [6] = '{TRK_NORMAL, TRK_NORMAL, TRK_NORMAL,
    TRK_HIGH_GAIN, TRK_REF, TRK_NORMAL};
  logic [7:0] lk_thr [6] = '{LOCK_CNT_REF, LOCK_CNT_NORMAL,
    LOCK_CNT_DOUBLE, LOCK_CNT_HIGH, LOCK_CNT_REF, LOCK_CNT_NORMAL};
  logic [6:0] wbits [8] = '{7'h08, 7'h0A, 7'h10, 7'h14, 7'h20, 7'h28,
    7'h40, 7'h50};
  // Amplifier says too large above the goal; eye peaks at setting 5.
  assign amp_out = dco_offset > DCO_GOAL;
  assign eye_area = (eq_setting == 3'h5) ? 16'h0300 : {13'h0, eq_setting};
  always #50 clk = ~clk;
  // Feedback stage answers one cycle after its start pulse; a hang ends the run as a failure.
  always @(posedge clk) begin
    dfe_done <= dfe_start;
    if (dfe_start) dfe_seen++;
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end
  rcm_lane_ctrl dut (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq),
    .tracking_mode_select(tracking_mode_select),
    .ref_phase_match(ref_phase_match), .data_transition(data_transition),
    .ser_bit(ser_bit), .ser_bit_en(ser_bit_en),
    .bit_slip_req(bit_slip_req), .recv_word_valid(recv_word_valid),
    .rx_word(rx_word), .rx_word_strobe(rx_word_strobe),
    .cdr_lock(cdr_lock), .dco_zero_input(dco_zero_input),
    .dco_offset(dco_offset), .amp_out(amp_out), .eq_setting(eq_setting),
    .eye_area(eye_area), .dfe_start(dfe_start), .dfe_done(dfe_done));
  rcm_fabric_model fabric (.clk(clk), .srst(srst), .slip_go(slip_go),
    .rude(rude), .recv_word_valid(recv_word_valid),
    .bit_slip_req(bit_slip_req), .ser_bit(ser_bit),
    .ser_bit_en(ser_bit_en));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; only the bench timeout ends a wait for ack.
  task automatic wb_io(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_io(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] q;
    wb_io(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic next_word(output logic [7:0] w, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rx_word_strobe !== 1'b1 && k < 200);
    w = rx_word[7:0];
    if (k >= 200) mismatches++;
  endtask
  task automatic slip(input logic extra);
    int k;
    slip_go <= 1'b1;
    for (k = 0; recv_word_valid !== 1'b0 && k < 20; k++) @(posedge clk);
    chk(recv_word_valid, 1'b0);
    rude <= extra;
    @(posedge clk);
    rude <= 1'b0;
    for (k = 0; recv_word_valid !== 1'b1 && k < 200; k++) @(posedge clk);
    chk(rx_word_strobe, 1'b1);
    slip_go <= 1'b0;
    next_word(w1, k);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd_chk(ADDR_CTRL, 32'hFFFFFFFF, {24'h0, CTRL_RESET});
    rd_chk(ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'hFFFFFFFF, 32'h0);
    rd_chk(ADDR_STATUS, 32'h3, 32'h2);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      tracking_mode_select <= lk_trk[i];
      wr(ADDR_CTRL, {24'h0, 6'h14, lk_mode[i]});
      ref_phase_match <= lk_mode[i] == MODE_REF || lk_trk[i] == TRK_REF;
      data_transition <= !(lk_mode[i] == MODE_REF || lk_trk[i] == TRK_REF);
      repeat (lk_thr[i] - 8'h02) @(posedge clk);
      chk(cdr_lock, 1'b0);
      repeat (5) @(posedge clk);
      chk(cdr_lock, 1'b1);
      rd_chk(ADDR_STATUS, 32'h1, 32'h1);
      if (i == 0) begin
        rd_chk(ADDR_IRQ_STAT, 32'hF, 32'h1);
        chk(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
      end
      ref_phase_match <= 1'b0;
      data_transition <= 1'b0;
      repeat (3) @(posedge clk);
      chk(cdr_lock, 1'b0);
    end
    $display("test lock done");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CTRL, {24'h0, 1'b0, c[2:0], 4'h5});
      // A narrower width leaves a long residue that flushes as a burst of
      // short words, so only a late word gives the steady spacing.
      repeat (8) next_word(w0, n);
      chk({25'h0, n[6:0]}, {25'h0, wbits[c]});
    end
    $display("test widths done");
    wr(ADDR_CTRL, 32'h01);
    slip_go <= 1'b1;
    repeat (20) @(posedge clk);
    chk(recv_word_valid, 1'b1);
    slip_go <= 1'b0;
    wr(ADDR_CTRL, 32'h05);
    repeat (2) next_word(w0, n);
    slip(1'b1);
    chk(w1, {w0[6:0], w0[7]});
    wr(ADDR_CTRL, 32'h0D);
    slip(1'b0);
    chk(w1, w0);
    rd_chk(ADDR_IRQ_STAT, 32'h8, 32'h8);
    $display("test shift done");
    wr(ADDR_IRQ_MASK, 32'h4);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_IRQ_STAT, 32'hF);
      wr(ADDR_CTRL, (k == 0) ? 32'h1D1 : 32'h1D2);
      for (n = 0; irq !== 1'b1 && n < 2000; n++) @(posedge clk);
      chk(irq, 1'b1);
      chk(dco_zero_input, 1'b0);
      chk(dco_offset, DCO_GOAL);
      chk(eq_setting, 3'h5);
      rd_chk(ADDR_STATUS, 32'h73F00, {13'h0, 3'h5, 2'h0, DCO_GOAL, 8'h0});
      chk(dfe_seen, 1);
    end
    $display("test calibration done");
    results();
  end
endmodule
`default_nettype wire
